// ==== rtl/ssx_core.sv ====
// Execution unit for set-all-ones, low-power entry and subtract-with-borrow
//
// Overview of operation
// - With a zero bank bit and the extended set on, f up to 5Fh is an offset from the index base.
// - The low-power opcode 0003h clears the power-down flag and sets the time-out flag.
// - The low-power opcode clears the watchdog counter and its postscaler.
// - After the low-power opcode the core halts with its oscillator stopped until a wake-up.
// - A wake-up caused by watchdog expiry clears the time-out flag.
// - The set instruction writes FFh to the file register and leaves every status flag alone.
// - A zero bank bit selects the access bank, a one selects the bank named by the bank register.
// - Subtract-with-borrow forms W - f - not C, into W when d is 0 and into f when d is 1.
//
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ssx_core #(
    parameter int NUM_BANKS = 2,
    parameter int WDT_PRESCALE = 1024,
    parameter int WDT_POSTSCALE = 128
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Wake-up pin, asynchronous
    input wire logic wake_pin,
    // Power state
    output logic osc_run,
    output logic sleeping,
    output logic power_down_flag,
    output logic timeout_flag
);
    import ssx_pkg::*;

    localparam int AW = $clog2(NUM_BANKS * 256);
    localparam int DEPTH = NUM_BANKS * 256;

    typedef enum {Q_IDLE, Q_ONE, Q_TWO, Q_THREE, Q_FOUR} ssx_q_t;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    ssx_q_t q_state;
    logic [1:0] ctrl;
    logic [15:0] instr;
    logic [7:0] wreg;
    logic [4:0] status;
    logic [3:0] bank_select_reg;
    logic [11:0] index_base;
    logic [AW-1:0] mem_ptr;
    logic [7:0] mem [DEPTH];
    logic [7:0] operand;
    logic [7:0] result;
    logic [4:0] next_status;
    logic [12:0] last_addr;
    logic wdt_awake;
    logic wake_meta;
    logic wake_sync;
    logic wdt_expire;
    logic wdt_clr;
    ssx_dec_t dec;
    ssx_addr_cfg_t cfg;
    logic [11:0] file_addr;
    logic file_indexed;
    logic [AW-1:0] file_idx;
    logic bus_req;
    logic bus_wr;
    logic busy;
    logic [8:0] diff;
    logic [4:0] diff_lo;
    logic q4_write;

    ////////////////////////////////////////////////////////////////////////////
    // Decode and address resolution

    function automatic ssx_dec_t decode(input logic [15:0] op);
        ssx_dec_t d;
        d.op = SSX_OP_NONE;
        d.to_file = 1'b0;
        d.banked = op[8];
        d.f = op[7:0];
        if (op == OPC_SLEEP) begin
            d.op = SSX_OP_SLEEP;
        end else if (op[15:9] == OPC_SET_HI) begin
            d.op = SSX_OP_SET;
            d.to_file = 1'b1;
        end else if (op[15:10] == OPC_SUB_HI) begin
            d.op = SSX_OP_SUB;
            d.to_file = op[9];
        end
        return d;
    endfunction

    assign dec = decode(instr);
    assign cfg = '{ext_en: ctrl[CTRL_EXT_BIT], bank_select_reg: bank_select_reg,
                   index_base: index_base};

    ssx_addr_map u_addr_map (
        .dec(dec),
        .cfg(cfg),
        .addr(file_addr),
        .indexed(file_indexed)
    );

    // Addresses beyond the built banks alias into them
    assign file_idx = file_addr[AW-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog and wake pin

    assign wdt_clr = (q_state == Q_FOUR) && (dec.op == SSX_OP_SLEEP);

    ssx_watchdog #(
        .PRESCALE(WDT_PRESCALE),
        .POSTSCALE(WDT_POSTSCALE)
    ) u_watchdog (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .en(ctrl[CTRL_WDT_BIT]),
        .clr(wdt_clr),
        .expire(wdt_expire)
    );

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
        end else begin
            wake_meta <= wake_pin;
            wake_sync <= wake_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after the request, write on the ack edge

    assign bus_req = wb_cyc_i && wb_stb_i;
    assign bus_wr = bus_req && wb_we_i && wb_ack_o;
    assign busy = (q_state != Q_IDLE);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req && !wb_ack_o;
            if (bus_req && !wb_ack_o) begin
                case (wb_adr_i)
                    OFF_CTRL: wb_dat_o <= {30'h0, ctrl};
                    OFF_INSTR: wb_dat_o <= {16'h0, instr};
                    OFF_WREG: wb_dat_o <= {24'h0, wreg};
                    OFF_STATUS: wb_dat_o <= {27'h0, status};
                    OFF_POWER: wb_dat_o <= {27'h0, wdt_awake, busy, sleeping,
                                            timeout_flag, power_down_flag};
                    OFF_BANK: wb_dat_o <= {28'h0, bank_select_reg};
                    OFF_INDEX: wb_dat_o <= {20'h0, index_base};
                    OFF_MEM_PTR: wb_dat_o <= 32'(mem_ptr);
                    OFF_MEM_DATA: wb_dat_o <= {24'h0, mem[mem_ptr]};
                    OFF_LAST_ADDR: wb_dat_o <= {19'h0, last_addr};
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    // Addressing settings; bank and index steady while an instruction runs, the extended bit in ctrl not
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= CTRL_RESET;
            bank_select_reg <= '0;
            index_base <= '0;
            mem_ptr <= '0;
        end else if (bus_wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                OFF_CTRL: ctrl <= wb_dat_i[1:0];
                OFF_BANK: bank_select_reg <= busy ? bank_select_reg : wb_dat_i[3:0];
                OFF_INDEX: index_base <= busy ? index_base : wb_dat_i[11:0];
                OFF_MEM_PTR: mem_ptr <= wb_dat_i[AW-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Q-phase sequencer

    // A new word is taken only when idle and awake, so a sleeping core ignores it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q_state <= Q_IDLE;
            instr <= '0;
        end else begin
            case (q_state)
                Q_IDLE: begin
                    if (bus_wr && wb_adr_i == OFF_INSTR && wb_sel_i[1:0] == 2'h3
                        && !sleeping) begin
                        instr <= wb_dat_i[15:0];
                        q_state <= Q_ONE;
                    end
                end
                Q_ONE: q_state <= Q_TWO;
                Q_TWO: q_state <= Q_THREE;
                Q_THREE: q_state <= Q_FOUR;
                Q_FOUR: q_state <= Q_IDLE;
                default: q_state <= Q_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath: read in Q2, process in Q3, write in Q4

    assign diff = {1'b0, wreg} - {1'b0, operand} - {8'h00, ~status[ST_C]};
    assign diff_lo = {1'b0, wreg[3:0]} - {1'b0, operand[3:0]} - {4'h0, ~status[ST_C]};
    assign q4_write = (q_state == Q_FOUR) && (dec.op == SSX_OP_SET || dec.op == SSX_OP_SUB);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            operand <= '0;
            result <= '0;
            next_status <= '0;
            last_addr <= '0;
        end else begin
            if (q_state == Q_TWO) begin
                operand <= mem[file_idx];
                last_addr <= {file_indexed, file_addr};
            end
            if (q_state == Q_THREE) begin
                result <= (dec.op == SSX_OP_SET) ? SET_VALUE : diff[7:0];
                next_status[ST_C] <= ~diff[8];
                next_status[ST_DC] <= ~diff_lo[4];
                next_status[ST_Z] <= (diff[7:0] == 8'h00);
                next_status[ST_N] <= diff[7];
                next_status[ST_OV] <= (wreg[7] ^ operand[7]) & (wreg[7] ^ diff[7]);
            end
        end
    end

    // Working register and status: only the subtract touches the flags
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wreg <= '0;
            status <= '0;
        end else if (q4_write && dec.op == SSX_OP_SUB) begin
            status <= next_status;
            if (!dec.to_file) begin
                wreg <= result;
            end
        end else if (bus_wr && !busy && wb_sel_i[0]) begin
            if (wb_adr_i == OFF_WREG) begin
                wreg <= wb_dat_i[7:0];
            end
            if (wb_adr_i == OFF_STATUS) begin
                status <= wb_dat_i[4:0];
            end
        end
    end

    // File registers; no reset so the array stays plain storage
    always_ff @(posedge sys_clk) begin
        if (q4_write && dec.to_file) begin
            mem[file_idx] <= result;
        end else if (bus_wr && !busy && wb_sel_i[0] && wb_adr_i == OFF_MEM_DATA) begin
            mem[mem_ptr] <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state and flags

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sleeping <= 1'b0;
            power_down_flag <= PWR_DOWN_RESET;
            timeout_flag <= TIMEOUT_RESET;
        end else begin
            if (q_state == Q_FOUR && dec.op == SSX_OP_SLEEP) begin
                power_down_flag <= 1'b0;
                timeout_flag <= 1'b1;
                sleeping <= 1'b1;
            end else if (sleeping && wdt_expire) begin
                timeout_flag <= 1'b0;
                sleeping <= 1'b0;
            end else if (sleeping && wake_sync) begin
                sleeping <= 1'b0;
            end
        end
    end

    // Oscillator gate follows the sleep state directly
    assign osc_run = !sleeping;

    // Expiry while awake would reset a real core; here it is only recorded
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wdt_awake <= 1'b0;
        end else if (wdt_expire && !sleeping) begin
            wdt_awake <= 1'b1;
        end else if (bus_wr && wb_sel_i[0] && wb_adr_i == OFF_POWER
                     && wb_dat_i[PW_WDT_AWAKE]) begin
            wdt_awake <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ssx_pkg.sv ====
// Shared constants and types for the three-instruction execution block
package ssx_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INSTR = 8'h04;
    localparam logic [7:0] OFF_WREG = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_POWER = 8'h10;
    localparam logic [7:0] OFF_BANK = 8'h14;
    localparam logic [7:0] OFF_INDEX = 8'h18;
    localparam logic [7:0] OFF_MEM_PTR = 8'h1c;
    localparam logic [7:0] OFF_MEM_DATA = 8'h20;
    localparam logic [7:0] OFF_LAST_ADDR = 8'h24;
    // Control bits
    localparam int CTRL_EXT_BIT = 0;
    localparam int CTRL_WDT_BIT = 1;
    // Arithmetic status bits
    localparam int ST_C = 0;
    localparam int ST_DC = 1;
    localparam int ST_Z = 2;
    localparam int ST_OV = 3;
    localparam int ST_N = 4;
    // Power register bits
    localparam int PW_PWR_DOWN = 0;
    localparam int PW_TIMEOUT = 1;
    localparam int PW_SLEEP = 2;
    localparam int PW_BUSY = 3;
    localparam int PW_WDT_AWAKE = 4;
    localparam int LAST_IDX_BIT = 12;
    // Opcode fields
    localparam logic [15:0] OPC_SLEEP = 16'h0003;
    localparam logic [6:0] OPC_SET_HI = 7'h34;
    localparam logic [5:0] OPC_SUB_HI = 6'h15;
    localparam logic [7:0] SET_VALUE = 8'hff;
    localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    // Reset values
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic PWR_DOWN_RESET = 1'b1;
    localparam logic TIMEOUT_RESET = 1'b1;

    typedef enum logic [1:0] {SSX_OP_NONE, SSX_OP_SET, SSX_OP_SUB, SSX_OP_SLEEP} ssx_op_t;

    // Decoded instruction word
    typedef struct packed {
        ssx_op_t op;
        logic to_file;
        logic banked;
        logic [7:0] f;
    } ssx_dec_t;

    // Address resolution settings
    typedef struct packed {
        logic ext_en;
        logic [3:0] bank_select_reg;
        logic [11:0] index_base;
    } ssx_addr_cfg_t;
endpackage

// ==== rtl/ssx_addr_map.sv ====
// File-address resolution for byte-oriented operands
`timescale 1ns/10ps
`default_nettype none
module ssx_addr_map (
    // Decoded operand and settings
    input wire ssx_pkg::ssx_dec_t dec,
    input wire ssx_pkg::ssx_addr_cfg_t cfg,
    // Resolved address
    output logic [11:0] addr,
    output logic indexed
);
    import ssx_pkg::*;

    always_comb begin
        indexed = !dec.banked && cfg.ext_en && (dec.f <= ACCESS_LIMIT);
        if (indexed) begin
            addr = cfg.index_base + {4'h0, dec.f};
        end else if (dec.banked) begin
            addr = {cfg.bank_select_reg, dec.f};
        end else if (dec.f <= ACCESS_LIMIT) begin
            addr = {ACCESS_LO_BANK, dec.f};
        end else begin
            addr = {ACCESS_HI_BANK, dec.f};
        end
    end
endmodule
`default_nettype wire

// ==== rtl/ssx_watchdog.sv ====
// Watchdog counter with prescaler and postscaler
`timescale 1ns/10ps
`default_nettype none
module ssx_watchdog #(
    parameter int PRESCALE = 1024,
    parameter int POSTSCALE = 128
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Control
    input wire logic en,
    input wire logic clr,
    // Expiry, one-cycle pulse
    output logic expire
);
    localparam int PW = $clog2(PRESCALE);
    localparam int QW = $clog2(POSTSCALE);
    localparam logic [PW-1:0] PRE_LAST = PW'(PRESCALE - 1);
    localparam logic [QW-1:0] POST_LAST = QW'(POSTSCALE - 1);

    logic [PW-1:0] pre;
    logic [QW-1:0] post;
    logic pre_wrap;

    assign pre_wrap = en && (pre == PRE_LAST);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            pre <= '0;
            post <= '0;
            expire <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (clr) begin
                pre <= '0;
                post <= '0;
            end else if (pre_wrap) begin
                pre <= '0;
                post <= (post == POST_LAST) ? '0 : post + 1'b1;
                expire <= (post == POST_LAST);
            end else if (en) begin
                pre <= pre + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== dv/ssx_core_monitor.sv ====
// Concurrent checks on the execution core ports
`timescale 1ns/10ps
`default_nettype none
module ssx_core_monitor import ssx_pkg::*; #(
    parameter int WDT_PRESCALE = 4,
    parameter int WDT_POSTSCALE = 2
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    // Power state
    input wire logic wake_pin,
    input wire logic osc_run,
    input wire logic sleeping,
    input wire logic power_down_flag,
    input wire logic timeout_flag
);
    localparam int SPAN = WDT_PRESCALE * WDT_POSTSCALE;
    logic [15:0] sleep_cnt;

    default clocking
        @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    // Length of each stay asleep
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sleep_cnt <= 16'h0000;
        end else if (sleeping) begin
            sleep_cnt <= sleep_cnt + 16'h0001;
        end else begin
            sleep_cnt <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_sleep_req;
        wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == OFF_INSTR &&
            wb_sel_i[1:0] == 2'b11 && wb_dat_i[15:0] == OPC_SLEEP && !sleeping;
    endsequence
    sequence s_enter;
        (!sleeping)[*5] ##1 (sleeping && !power_down_flag && timeout_flag);
    endsequence

    AST_SLEEP_ENTRY: assert property (s_sleep_req |-> s_enter)
        else $error("sleep entry timing or flags wrong");
    AST_OSC_STOP: assert property (osc_run != sleeping)
        else $error("oscillator state disagrees with sleep state");
    // Pin to sleep exit is three edges: two sync stages plus the state update
    AST_PIN_WAKE: assert property ($fell(sleeping) && timeout_flag |->
        $past(wake_pin, 3))
        else $error("left sleep without a wake cause");
    AST_TIMEOUT_FALL: assert property ($fell(timeout_flag) |-> $fell(sleeping))
        else $error("time-out flag cleared outside a watchdog wake");
    AST_TIMEOUT_RISE: assert property ($rose(timeout_flag) |->
        $rose(sleeping) && !power_down_flag)
        else $error("time-out flag set outside sleep entry");
    AST_PWRDN_FALL: assert property ($fell(power_down_flag) |-> $rose(sleeping))
        else $error("power-down flag cleared outside sleep entry");
    AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer not a single cycle later");
    AST_WDT_SPAN: assert property ($fell(sleeping) && !timeout_flag |->
        sleep_cnt >= 16'(SPAN - 1) && sleep_cnt <= 16'(SPAN + 2))
        else $error("watchdog wake after wrong sleep length");
endmodule

bind ssx_core ssx_core_monitor #(
    .WDT_PRESCALE(WDT_PRESCALE),
    .WDT_POSTSCALE(WDT_POSTSCALE)
) ssx_core_monitor_i (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o),
    .wake_pin(wake_pin),
    .osc_run(osc_run),
    .sleeping(sleeping),
    .power_down_flag(power_down_flag),
    .timeout_flag(timeout_flag)
);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the execution core
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ssx_pkg::*;
    localparam int PQ = 8;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic wake = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, osc_run, sleeping, power_down_flag, timeout_flag;
    logic [39:0] exp_q[$];
    int num_errors = 0;
    int num_checks = 0;

    ssx_core #(.NUM_BANKS(2), .WDT_PRESCALE(4), .WDT_POSTSCALE(2)) ssx_core_i (
        .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wake_pin(wake), .osc_run(osc_run), .sleeping(sleeping),
        .power_down_flag(power_down_flag), .timeout_flag(timeout_flag)
    );

    always #20 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One classic cycle; reads leave their expectation for the read check below
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      input logic [31:0] e);
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        if (!w) exp_q.push_back({a, e});
        // No own limit: a missing ack is caught by the bench timeout
        do begin
            @(posedge sys_clk);
        end while (wb_ack_o !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(a, 1'b1, d, 32'h0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0, e);
    endtask

    // Busy clears four cycles after the write edge
    task automatic exec(input logic [15:0] op);
        wr(OFF_INSTR, {16'h0000, op});
        repeat (5) @(posedge sys_clk);
    endtask

    // Read data is taken at the edge where ack is seen
    always @(posedge sys_clk) begin
        logic [39:0] x;
        if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
            x = exp_q.pop_front();
            check($sformatf("read at %h", x[39:32]), wb_dat_o, x[31:0]);
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        end_sim();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] w8, f8, res;
        logic [8:0] r9;
        logic [4:0] n5, st;
        logic c, d;
        int n;
        void'($urandom(10));
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(OFF_POWER, 32'h3);
        rd(OFF_CTRL, 32'h0);
        // Set instruction across access, banked and high access addresses
        st = 5'($urandom);
        wr(OFF_STATUS, {27'h0, st});
        wr(OFF_BANK, 32'h1);
        wr(OFF_MEM_PTR, 32'h010);
        wr(OFF_MEM_DATA, 32'h5a);
        exec(16'h6810);
        rd(OFF_LAST_ADDR, 32'h010);
        rd(OFF_MEM_DATA, 32'hff);
        exec(16'h6920);
        rd(OFF_LAST_ADDR, 32'h120);
        exec(16'h6880);
        rd(OFF_LAST_ADDR, 32'hf80);
        rd(OFF_STATUS, {27'h0, st});
        // Indexed mode at and beyond the offset limit
        wr(OFF_CTRL, 32'h1);
        wr(OFF_INDEX, 32'h100);
        exec(16'h685f);
        rd(OFF_LAST_ADDR, 32'h115f);
        exec(16'h6860);
        rd(OFF_LAST_ADDR, 32'hf60);
        exec(16'h695f);
        rd(OFF_LAST_ADDR, 32'h15f);
        wr(OFF_CTRL, 32'h0);
        // Subtract with borrow, both destinations
        for (int i = 0; i < 12; i++) begin
            w8 = 8'($urandom);
            f8 = 8'($urandom);
            c = 1'($urandom);
            d = i[0];
            wr(OFF_MEM_PTR, 32'h030);
            wr(OFF_MEM_DATA, {24'h0, f8});
            wr(OFF_WREG, {24'h0, w8});
            wr(OFF_STATUS, {31'h0, c});
            exec({OPC_SUB_HI, d, 1'b0, 8'h30});
            r9 = {1'b0, w8} - {1'b0, f8} - {8'h00, !c};
            n5 = {1'b0, w8[3:0]} - {1'b0, f8[3:0]} - {4'h0, !c};
            res = r9[7:0];
            rd(OFF_WREG, {24'h0, d ? w8 : res});
            rd(OFF_MEM_DATA, {24'h0, d ? res : f8});
            rd(OFF_STATUS, {27'h0, res[7], (w8[7] != f8[7]) && (res[7] != w8[7]),
                res == 8'h00, !n5[4], !r9[8]});
        end
        // Sleep, stay halted, leave by the wake pin
        exec(OPC_SLEEP);
        rd(OFF_POWER, 32'h6);
        repeat (30) @(posedge sys_clk);
        check("osc_run", 32'(osc_run), 32'h0);
        wake <= 1'b1;
        repeat (6) @(posedge sys_clk);
        wake <= 1'b0;
        rd(OFF_POWER, 32'h2);
        // Watchdog wake; counter must restart at sleep entry
        wr(OFF_CTRL, 32'h2);
        wr(OFF_INSTR, {16'h0000, OPC_SLEEP});
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (!(n > 6 && sleeping === 1'b0) && n < 200);
        check("wake delay", 32'(n >= PQ + 2 && n <= PQ + 8), 32'h1);
        check("timeout_flag", 32'(timeout_flag), 32'h0);
        check("power_down_flag", 32'(power_down_flag), 32'h0);
        wr(OFF_CTRL, 32'h0);
        // Sleep again from a cleared time-out flag
        exec(OPC_SLEEP);
        check("timeout_flag", 32'(timeout_flag), 32'h1);
        check("sleeping", 32'(sleeping), 32'h1);
        wake <= 1'b1;
        repeat (6) @(posedge sys_clk);
        wake <= 1'b0;
        check("sleeping", 32'(sleeping), 32'h0);
        repeat (3) @(posedge sys_clk);
        end_sim();
    end
endmodule
`default_nettype wire
